//--- rtl/dgc_arbiter.v
// Four-channel arbiter, fixed or rotating priority.
// Assumes requests already qualified; last-served pointer from the caller.
`timescale 1ns/1ps
`default_nettype none
module dgc_arbiter (
  // Request side
  input wire [3:0] req_i,
  input wire rotate_i,
  input wire [1:0] last_i,
  // Grant side
  output reg grant_valid_o,
  output reg [1:0] grant_chan_o
);
  // ----------------------------------------
  // Priority search
  // ----------------------------------------
  reg [1:0] start; // First channel searched
  reg [1:0] idx; // Candidate channel
  integer k;
  // Search from start upward, wrapping
  always @* begin
    start = rotate_i ? last_i + 2'h1 : 2'h0;
    grant_valid_o = 1'b0;
    grant_chan_o = 2'h0;
    idx = 2'h0;
    for (k = 3; k >= 0; k = k - 1) begin
      idx = start + k[1:0];
      if (req_i[idx]) begin
        grant_valid_o = 1'b1;
        grant_chan_o = idx;
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/dgc_map.vh
// Register offsets, field positions and reset values for the DMA group control block.
// Assumes inclusion by bare name from the design files.
`ifndef DGC_MAP_VH
`define DGC_MAP_VH
// ----------------------------------------
// Register offsets (byte-wide I/O space)
// ----------------------------------------
`define DGC_OFS_GROUP_CONTROL 4'h8
`define DGC_OFS_SW_REQUEST 4'h9
// ----------------------------------------
// Group control field positions
// ----------------------------------------
`define DGC_BIT_ACK_POL 7
`define DGC_BIT_REQ_POL 6
`define DGC_BIT_EARLY_WR 5
`define DGC_BIT_PRIO 4
`define DGC_BIT_COMP 3
`define DGC_BIT_REQ_DIS 2
// ----------------------------------------
// Software request field positions
// ----------------------------------------
`define DGC_BIT_SW_VAL 2
`define DGC_SW_SEL_HI 1
`define DGC_SW_SEL_LO 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define DGC_RST_GROUP_CONTROL 6'h00
`define DGC_RST_SW_FLAGS 4'h0
`define DGC_RST_LAST_CHAN 2'h3
// ----------------------------------------
// Timing counts (clocks)
// ----------------------------------------
`define DGC_STROBE_NORMAL 3'h3
`define DGC_STROBE_COMP 3'h1
`define DGC_EARLY_LEAD 3'h1
`endif

//--- rtl/dgc_top.v
// DMA group control: global control register, software request register,
// request polarity, arbitration, acknowledge polarity and strobe timing.
// Assumes synchronous byte-wide I/O writes; peripheral requests come from pins.
//
// Overview of operation
// - Ack outputs low active when bit7 zero
// - Request inputs high active when bit6 zero
// - Early write advances write strobes one clock
// - Compressed timing overrides early write setting
// - Bit4 selects fixed or rotating priority
// - Compressed timing gives one-clock read strobes
// - Request disable ignores requests, registers stay
// - Software request register at offset 9h
// - Write sets or clears selected request flag
// - Terminal count clears software request flag
// - Write-only control byte at offset 8h
`timescale 1ns/1ps
`default_nettype none
`include "dgc_map.vh"
module dgc_top (
  // Clock, reset, enable
  input wire clk_i,
  input wire nrst_i,
  input wire ce_i,
  // Register write port
  input wire wr_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  // Peripheral pins
  input wire [3:0] dreq_i,
  output reg [3:0] dack_o,
  // Transfer engine side
  input wire cycle_is_read_i,
  input wire cycle_is_mem_i,
  input wire [3:0] tc_i,
  // Bus strobes, active high
  output reg io_read_strobe_o,
  output reg mem_read_strobe_o,
  output reg io_write_strobe_o,
  output reg mem_write_strobe_o,
  // Status
  output reg [3:0] sw_req_flags_o,
  output reg [5:0] group_control_o
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_ACT = 2'b01;
  localparam ST_DONE = 2'b10;

  // Decode of a write to one offset
  function is_wr;
    input wr;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      is_wr = wr & (addr == ofs);
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers (three stages)
  // ----------------------------------------
  reg [3:0] dreq_s1_q, dreq_s2_q, dreq_s3_q; // Sync chain
  reg [3:0] dreq_q; // Filtered request level
  // Sample the pins
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dreq_s1_q <= 4'h0;
      dreq_s2_q <= 4'h0;
      dreq_s3_q <= 4'h0;
      dreq_q <= 4'h0;
    end else if (ce_i) begin
      dreq_s1_q <= dreq_i;
      dreq_s2_q <= dreq_s1_q;
      dreq_s3_q <= dreq_s2_q;
      // Accept change when stages two and three agree
      dreq_q <= (dreq_s2_q & dreq_s3_q) | (dreq_q & (dreq_s2_q | dreq_s3_q));
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  wire wr_ctl = is_wr(wr_i, addr_i, `DGC_OFS_GROUP_CONTROL);
  wire wr_swr = is_wr(wr_i, addr_i, `DGC_OFS_SW_REQUEST);
  reg [5:0] ctl_q; // Bits 7..2 only; reserved bits unstored
  reg [3:0] swf_q; // Software request flags
  wire [1:0] sel = wdata_i[`DGC_SW_SEL_HI:`DGC_SW_SEL_LO];
  reg [3:0] swf_d;
  integer c;
  // Software flag next value
  always @* begin
    swf_d = swf_q & ~tc_i;
    for (c = 0; c < 4; c = c + 1) begin
      if (wr_swr && sel == c[1:0]) begin
        swf_d[c] = wdata_i[`DGC_BIT_SW_VAL];
      end
    end
  end
  // Control and flag storage
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_q <= `DGC_RST_GROUP_CONTROL;
      swf_q <= `DGC_RST_SW_FLAGS;
    end else if (ce_i) begin
      if (wr_ctl) begin
        ctl_q <= wdata_i[7:2];
      end
      swf_q <= swf_d;
    end
  end

  wire ack_pol = ctl_q[`DGC_BIT_ACK_POL-2];
  wire req_pol = ctl_q[`DGC_BIT_REQ_POL-2];
  wire early_write_sel = ctl_q[`DGC_BIT_EARLY_WR-2];
  wire priority_scheme = ctl_q[`DGC_BIT_PRIO-2];
  wire compressed_timing = ctl_q[`DGC_BIT_COMP-2];
  wire request_disable = ctl_q[`DGC_BIT_REQ_DIS-2];

  // ----------------------------------------
  // Request qualification and arbitration
  // ----------------------------------------
  wire [3:0] hw_req = req_pol ? ~dreq_q : dreq_q;
  wire [3:0] req_all = request_disable ? 4'h0 : (hw_req | swf_q);
  reg [1:0] last_q; // Most recently served channel
  wire gv;
  wire [1:0] gch;
  dgc_arbiter u_arb (
    .req_i(req_all),
    .rotate_i(priority_scheme),
    .last_i(last_q),
    .grant_valid_o(gv),
    .grant_chan_o(gch)
  );

  // ----------------------------------------
  // Service sequencer
  // ----------------------------------------
  reg [1:0] st_q; // Sequencer state
  reg [1:0] ch_q; // Channel in service
  reg [2:0] cnt_q; // Cycle counter within transfer
  reg rd_q, mem_q; // Kind of cycle
  wire [2:0] len = compressed_timing ? `DGC_STROBE_COMP : `DGC_STROBE_NORMAL;
  wire early = early_write_sel & ~compressed_timing;
  // Strobe active test for a cycle position
  wire strobe_on = (st_q == ST_ACT) &&
    (rd_q ? (cnt_q < len) : (early ? 1'b1 : (cnt_q >= `DGC_EARLY_LEAD)));
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= ST_IDLE;
      ch_q <= 2'h0;
      cnt_q <= 3'h0;
      rd_q <= 1'b0;
      mem_q <= 1'b0;
      last_q <= `DGC_RST_LAST_CHAN;
    end else if (ce_i) begin
      case (st_q)
        ST_IDLE: begin
          // Grant winner
          if (gv) begin
            st_q <= ST_ACT;
            ch_q <= gch;
            cnt_q <= 3'h0;
            rd_q <= cycle_is_read_i;
            mem_q <= cycle_is_mem_i;
          end
        end
        ST_ACT: begin
          // Normal cycle is three clocks; read may be compressed
          if (cnt_q == (rd_q ? len : `DGC_STROBE_NORMAL) - 3'h1) begin
            st_q <= ST_DONE;
            last_q <= ch_q;
          end
          cnt_q <= cnt_q + 3'h1;
        end
        ST_DONE: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  reg [3:0] ack_d;
  integer a;
  // Acknowledge pattern for current service
  always @* begin
    for (a = 0; a < 4; a = a + 1) begin
      ack_d[a] = ((st_q == ST_ACT) && ch_q == a[1:0]) ^ ~ack_pol;
    end
  end
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dack_o <= 4'hF;
      io_read_strobe_o <= 1'b0;
      mem_read_strobe_o <= 1'b0;
      io_write_strobe_o <= 1'b0;
      mem_write_strobe_o <= 1'b0;
      sw_req_flags_o <= `DGC_RST_SW_FLAGS;
      group_control_o <= `DGC_RST_GROUP_CONTROL;
    end else if (ce_i) begin
      dack_o <= ack_d;
      io_read_strobe_o <= strobe_on & rd_q & ~mem_q;
      mem_read_strobe_o <= strobe_on & rd_q & mem_q;
      io_write_strobe_o <= strobe_on & ~rd_q & ~mem_q;
      mem_write_strobe_o <= strobe_on & ~rd_q & mem_q;
      sw_req_flags_o <= swf_q;
      group_control_o <= ctl_q;
    end
  end
endmodule
`default_nettype wire

//--- verif/dgc_periph.sv
// Peripheral model: level request per channel, dropped once acknowledged.
// Assumes bench go pulses and polarity settings that match the control byte.
`timescale 1ns/1ps
`default_nettype none
module dgc_periph (
  // Clock, reset, bench control
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] go_i,
  input wire logic ack_hi_i,
  input wire logic req_low_i,
  // Pins
  input wire logic [3:0] ack_i,
  output logic [3:0] dreq_o
);
  logic [3:0] pend_q = 4'h0; // Outstanding requests
  // Hold each request until its acknowledge is seen
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) pend_q <= 4'h0;
    else pend_q <= (pend_q | go_i) & ~(ack_hi_i ? ack_i : ~ack_i);
  end
  assign dreq_o = req_low_i ? ~pend_q : pend_q;
endmodule
`default_nettype wire

//--- verif/dgc_props.sv
// Checker for the DMA group control top: registers, strobes, acknowledges.
// Assumes it is bound to dgc_top and watches its ports only.
`timescale 1ns/1ps
`default_nettype none
module dgc_props (
  // Clock, reset, writes
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [3:0] tc_i,
  // Outputs
  input wire logic [3:0] dack_o,
  input wire logic io_read_strobe_o,
  input wire logic mem_read_strobe_o,
  input wire logic io_write_strobe_o,
  input wire logic mem_write_strobe_o,
  input wire logic [3:0] sw_req_flags_o,
  input wire logic [5:0] group_control_o
);
  wire rd = io_read_strobe_o | mem_read_strobe_o; // Any read strobe
  wire ws = io_write_strobe_o | mem_write_strobe_o; // Any write strobe
  wire [3:0] idle = {4{~group_control_o[5]}}; // Acknowledge idle level
  wire early = group_control_o[3] & ~group_control_o[1]; // Early write in force
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_ctl_store: assert property (wr_i && ce_i && addr_i == 4'h8 |-> ##2 group_control_o == $past(wdata_i[7:2], 2))
    else $error("control byte not held");
  chk_sw_flag: assert property (wr_i && ce_i && addr_i == 4'h9 |-> ##2
    sw_req_flags_o[$past(wdata_i[1:0], 2)] == $past(wdata_i[2], 2))
    else $error("software flag wrong");
  chk_tc_clear: assert property (ce_i && tc_i[0] && !(wr_i && addr_i == 4'h9) |-> ##2 !sw_req_flags_o[0])
    else $error("flag kept after terminal count");
  chk_read_comp: assert property ($rose(rd) && group_control_o[1] |=> !rd)
    else $error("compressed read too long");
  chk_read_norm: assert property ($rose(rd) && !group_control_o[1] |-> rd [*3] ##1 !rd)
    else $error("normal read length wrong");
  chk_write_early: assert property ($rose(ws) && early |-> ws [*3] ##1 !ws)
    else $error("early write length wrong");
  chk_write_late: assert property ($rose(ws) && !early |-> ws [*2] ##1 !ws)
    else $error("late write length wrong");
  chk_disable_idle: assert property (group_control_o[0] [*8] |-> dack_o == idle)
    else $error("acknowledge while disabled");
  chk_ack_single: assert property (group_control_o == $past(group_control_o, 2) |-> $onehot0(dack_o ^ idle))
    else $error("more than one acknowledge");
  chk_strobe_ack: assert property (rd || ws |-> dack_o != idle)
    else $error("strobe without acknowledge");
endmodule
bind dgc_top dgc_props dgc_props_i (.*);
`default_nettype wire

//--- verif/dgc_top_bench.sv
// Self-checking bench for the DMA group control top.
// Assumes the peripheral model and bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module dgc_top_bench;
  logic clk_i = 1'h0, nrst_i = 1'h0, wr_i = 1'h0, rd = 1'h1, mem = 1'h0, ackhi = 1'h0, lowq = 1'h0, ce = 1'h1;
  logic [3:0] addr_i = 4'h0, tc = 4'h0, go = 4'h0, act_q = 4'h0, dreq, dack, flags;
  logic [7:0] wdata_i = 8'h00, ord = 8'h00;
  logic [5:0] gc;
  logic ird, mrd, iwr, mwr;
  int fails = 0, n_tests = 0;
  wire [3:0] act = ackhi ? dack : ~dack; // Acknowledges in force
  dgc_top dgc_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce), .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .dreq_i(dreq), .dack_o(dack), .cycle_is_read_i(rd), .cycle_is_mem_i(mem), .tc_i(tc), .io_read_strobe_o(ird),
    .mem_read_strobe_o(mrd), .io_write_strobe_o(iwr), .mem_write_strobe_o(mwr), .sw_req_flags_o(flags),
    .group_control_o(gc));
  dgc_periph dgc_periph_i (.clk_i(clk_i), .nrst_i(nrst_i), .go_i(go), .ack_hi_i(ackhi), .req_low_i(lowq),
    .ack_i(dack), .dreq_o(dreq));
  initial forever #25 clk_i = ~clk_i;
  // Engine stand-in ends each transfer; monitor logs grant order
  always @(negedge clk_i) tc <= act;
  always @(posedge clk_i) begin
    act_q <= act;
    if ((act & ~act_q) != 4'h0) ord <= {ord[5:0], act[3] ? 2'h3 : act[2] ? 2'h2 : act[1] ? 2'h1 : 2'h0};
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(negedge clk_i) {wr_i, addr_i, wdata_i} = {1'h1, a, d};
    @(negedge clk_i) wr_i = 1'h0;
    @(negedge clk_i);
  endtask
  // Reset values, reserved bits, unmapped offset
  task automatic t_regs;
    chk("control", 8'h00, gc);
    chk("ack", 8'h0F, dack);
    chk("strobes", 8'h00, {ird, mrd, iwr, mwr});
    wr(4'h8, 8'h07);
    chk("control", 8'h01, gc);
    wr(4'h9, 8'hFF);
    chk("flags", 8'h08, flags);
    wr(4'hA, 8'hFF);
    chk("control", 8'h01, gc);
    ce = 1'h0; // Frozen clock enable must drop the write
    wr(4'h8, 8'hFC);
    ce = 1'h1;
    chk("control", 8'h01, gc);
    wr(4'h9, 8'h03);
    chk("flags", 8'h00, flags);
  endtask
  // One pin transfer: strobe length and channel acknowledged
  task automatic xfer(logic [7:0] c, logic r, logic m, logic [1:0] ch, int n);
    int len = 0;
    int got = 9;
    wr(4'h8, c | 8'h04);
    {ackhi, lowq, rd, mem} = {c[7], c[6], r, m};
    repeat (6) @(negedge clk_i);
    wr(4'h8, c);
    @(negedge clk_i) go[ch] = 1'h1;
    @(negedge clk_i) go = 4'h0;
    for (int i = 0; i < 40 && !(got != 9 && act == 4'h0); i++) begin
      if (act != 4'h0) got = act[3] ? 3 : act[2] ? 2 : act[1] ? 1 : 0;
      len += r ? (m ? mrd : ird) : (m ? mwr : iwr);
      @(negedge clk_i);
    end
    chk("strobe length", 8'(n), 8'(len));
    chk("channel", n ? 8'(ch) : 8'h09, 8'(got));
    if (n == 0) wr(4'h8, 8'h00); // Serve the request held off while disabled
    repeat (30) @(negedge clk_i);
  endtask
  // Two rounds of software requests set while disabled
  task automatic prio(logic [7:0] c, logic [3:0] m1, logic [3:0] m2, logic [7:0] e);
    {ackhi, lowq} = 2'h0;
    for (int s = 0; s < 2; s++) begin
      wr(4'h8, c | 8'h04);
      repeat (6) @(negedge clk_i);
      for (int k = 0; k < 4; k++) if (s ? m2[k] : m1[k]) wr(4'h9, 8'(k) | 8'h04);
      if (s == 0) ord = 8'h00;
      wr(4'h8, c);
      repeat (40) @(negedge clk_i);
    end
    chk("grant order", e, ord);
    chk("flags", 8'h00, flags);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk_i);
    nrst_i = 1'h1;
    t_regs();
    xfer(8'h00, 1'h1, 1'h0, 2'h0, 3);
    xfer(8'h08, 1'h1, 1'h1, 2'h1, 1);
    xfer(8'h00, 1'h0, 1'h0, 2'h2, 2);
    xfer(8'h20, 1'h0, 1'h1, 2'h3, 3);
    xfer(8'h28, 1'h0, 1'h0, 2'h0, 2);
    xfer(8'h04, 1'h1, 1'h0, 2'h1, 0);
    xfer(8'hC0, 1'h1, 1'h1, 2'h1, 3);
    prio(8'h00, 4'h8, 4'hB, 8'hC7);
    prio(8'h10, 4'h2, 4'hD, 8'h6C);
    tally_and_finish();
  end
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
